// [include/sum_pkg.sv]
package sum_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses: word index times four, so offsets are multiples of four)
    // ----------------------------------------------------------------
    localparam logic [7:0]  COMPUTE_CONTROL_IDX = 8'hef;
    localparam logic [7:0]  SUM_RESULT_LOW_IDX  = 8'hfc;
    localparam logic [7:0]  SUM_RESULT_HIGH_IDX = 8'hfd;
    localparam logic [11:0] COMPUTE_CONTROL_ADDR = {2'h0, COMPUTE_CONTROL_IDX, 2'h0};
    localparam logic [11:0] SUM_RESULT_LOW_ADDR  = {2'h0, SUM_RESULT_LOW_IDX, 2'h0};
    localparam logic [11:0] SUM_RESULT_HIGH_ADDR = {2'h0, SUM_RESULT_HIGH_IDX, 2'h0};
    localparam logic [11:0] STATUS_ADDR          = 12'h400;
    // ----------------------------------------------------------------
    // fields, reset values and scan address range
    // ----------------------------------------------------------------
    localparam int          START_BIT       = 0;
    localparam int          BUSY_BIT        = 0;
    localparam logic [7:0]  RESULT_RESET    = 8'h00;
    localparam logic [13:0] CODE_FIRST_ADDR = 14'h0000;
    localparam logic [13:0] CODE_LAST_ADDR  = 14'h3ffd;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_ADD
    } sum_state_type;
endpackage

// [tb/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals and code memory model
    // ----------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [13:0] code_addr;
    logic        code_rd;
    logic [7:0]  code_data = 8'h00;
    logic [7:0]  mem [0:16383];
    logic [31:0] seed = 32'h00000016;
    logic [31:0] q;
    logic [31:0] r;
    logic        e;
    int          bad_count = 0;
    int          tests_run = 0;

    always #20 pclk = ~pclk;

    code_memory_checksum dut (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .code_addr (code_addr),
        .code_rd   (code_rd),
        .code_data (code_data)
    );

    // outside a read the bus shows the inverse, so a stale byte cannot pass
    always @(posedge pclk) code_data <= code_rd ? mem[code_addr] : ~code_data;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [15:0] exp_sum();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i <= int'(sum_pkg::CODE_LAST_ADDR); i++) s = s + 16'(mem[i]);
        return s;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // called just after a rising edge; read data and error are taken at the
    // edge where pready is seen high, then one idle cycle separates transfers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20) chk(32'h0, 32'h1, "pready never came");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #(40 * 90000);
        bad_count++;
        final_report();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int          n;
        logic [15:0] x;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        for (int i = 0; i < 16384; i++) begin
            r = xs();
            mem[i] = r[7:0];
        end
        // bytes past the summed range are all ones, so including them would show
        mem[16382] = 8'hff;
        mem[16383] = 8'hff;
        x = exp_sum();
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, sum_pkg::SUM_RESULT_LOW_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_0000, "low after reset");
        apb(1'b0, sum_pkg::SUM_RESULT_HIGH_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_0000, "high after reset");
        $display("test reset values done");
        r = xs();
        apb(1'b1, sum_pkg::SUM_RESULT_LOW_ADDR, r);
        apb(1'b1, sum_pkg::SUM_RESULT_HIGH_ADDR, ~r);
        apb(1'b0, sum_pkg::SUM_RESULT_LOW_ADDR, 32'h0000_0000);
        chk(q, {24'h000000, r[7:0]}, "low write back");
        apb(1'b0, sum_pkg::SUM_RESULT_HIGH_ADDR, 32'h0000_0000);
        chk(q, {24'h000000, ~r[7:0]}, "high write back");
        $display("test result access done");
        apb(1'b1, sum_pkg::COMPUTE_CONTROL_ADDR, xs() & 32'hffff_fffe);
        apb(1'b0, sum_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(q & 32'h0000_0001, 32'h0000_0000, "zero start began a run");
        apb(1'b0, sum_pkg::SUM_RESULT_LOW_ADDR, 32'h0000_0000);
        chk(q, {24'h000000, r[7:0]}, "zero start touched result");
        apb(1'b0, 12'h3c0, 32'h0000_0000);
        chk({31'h00000000, e}, 32'h0000_0001, "unmapped address accepted");
        $display("test zero start and unmapped done");
        apb(1'b1, sum_pkg::COMPUTE_CONTROL_ADDR, xs() | 32'h0000_0001);
        apb(1'b1, sum_pkg::COMPUTE_CONTROL_ADDR, 32'h0000_0000);
        apb(1'b0, sum_pkg::STATUS_ADDR, 32'h0000_0000);
        chk(q & 32'h0000_0001, 32'h0000_0001, "run not busy");
        // a second start at a random point of the scan rescans from the bottom
        r = xs();
        repeat (r[2:0]) @(posedge pclk);
        apb(1'b1, sum_pkg::COMPUTE_CONTROL_ADDR, 32'h0000_0001);
        n = 0;
        q = 32'h0000_0001;
        while ((q & 32'h0000_0001) !== 32'h0000_0000 && n < 20000) begin
            apb(1'b0, sum_pkg::STATUS_ADDR, 32'h0000_0000);
            n++;
        end
        chk({31'h00000000, n < 20000}, 32'h0000_0001, "run never ended");
        apb(1'b0, sum_pkg::SUM_RESULT_LOW_ADDR, 32'h0000_0000);
        chk(q, {24'h000000, x[7:0]}, "sum low byte");
        apb(1'b0, sum_pkg::SUM_RESULT_HIGH_ADDR, 32'h0000_0000);
        chk(q, {24'h000000, x[15:8]}, "sum high byte");
        $display("test checksum run done");
        apb(1'b1, sum_pkg::COMPUTE_CONTROL_ADDR, 32'h0000_0001);
        repeat (9) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, sum_pkg::SUM_RESULT_LOW_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_0000, "low after mid-run reset");
        apb(1'b0, sum_pkg::SUM_RESULT_HIGH_ADDR, 32'h0000_0000);
        chk(q, 32'h0000_0000, "high after mid-run reset");
        $display("test mid-run reset done");
        final_report();
    end
endmodule

// [verilog/byte_accumulator.sv]
module byte_accumulator #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clear,
    input  wire logic             add_en,
    input  wire logic [7:0]       data_in,
    output logic      [WIDTH-1:0] sum
);
    typedef struct packed {
        logic [WIDTH-1:0] acc;
    } acc_state_type;

    acc_state_type s_r;
    acc_state_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt.acc = '0;
        end else if (add_en) begin
            // carry beyond the top bit is dropped, so the sum wraps
            s_nxt.acc = s_r.acc + {{(WIDTH-8){1'b0}}, data_in};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sum = s_r.acc;
endmodule

// [verilog/code_memory_checksum.sv]
module code_memory_checksum #(
    parameter int ADDR_W = 14
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [ADDR_W-1:0] code_addr,
    output logic                   code_rd,
    input  wire logic [7:0]        code_data
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        sum_pkg::sum_state_type state;
        logic [ADDR_W-1:0]      addr;
        logic                   rd;
        logic [7:0]             res_lo;
        logic [7:0]             res_hi;
        logic [31:0]            rdata;
        logic                   ready;
        logic                   err;
    } top_state_type;

    top_state_type s_r;
    top_state_type s_nxt;

    logic        acc_clear;
    logic        acc_add;
    logic [15:0] acc_sum;
    logic        setup;
    logic        wr_take;
    logic        start_req;
    logic        mapped;

    byte_accumulator #(
        .WIDTH (16)
    ) u_acc (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (acc_clear),
        .add_en  (acc_add),
        .data_in (code_data),
        .sum     (acc_sum)
    );

    // ----------------------------------------------------------------
    // apb: no wait states; setup cycle prepares the answer
    // ----------------------------------------------------------------
    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pwrite && s_r.ready;
    assign mapped  = (paddr == sum_pkg::COMPUTE_CONTROL_ADDR) ||
                     (paddr == sum_pkg::SUM_RESULT_LOW_ADDR) ||
                     (paddr == sum_pkg::SUM_RESULT_HIGH_ADDR) ||
                     (paddr == sum_pkg::STATUS_ADDR);
    assign start_req = wr_take && (paddr == sum_pkg::COMPUTE_CONTROL_ADDR)
                       && pwdata[sum_pkg::START_BIT];

    always_comb begin
        s_nxt     = s_r;
        acc_clear = 1'b0;
        acc_add   = 1'b0;
        s_nxt.ready = setup;
        if (setup) begin
            s_nxt.err   = !mapped;
            s_nxt.rdata = 32'h0000_0000;
            case (paddr)
                sum_pkg::SUM_RESULT_LOW_ADDR:  s_nxt.rdata[7:0] = s_r.res_lo;
                sum_pkg::SUM_RESULT_HIGH_ADDR: s_nxt.rdata[7:0] = s_r.res_hi;
                sum_pkg::STATUS_ADDR: begin
                    s_nxt.rdata[sum_pkg::BUSY_BIT] = (s_r.state != sum_pkg::ST_IDLE);
                end
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end else begin
            // error stands only in the access cycle, alongside pready
            s_nxt.err = 1'b0;
        end
        // result bytes are software-writable, as the map allows
        if (wr_take && paddr == sum_pkg::SUM_RESULT_LOW_ADDR) begin
            s_nxt.res_lo = pwdata[7:0];
        end
        if (wr_take && paddr == sum_pkg::SUM_RESULT_HIGH_ADDR) begin
            s_nxt.res_hi = pwdata[7:0];
        end
        // ------------------------------------------------------------
        // engine: one byte per two cycles (address, then data)
        // ------------------------------------------------------------
        s_nxt.rd = 1'b0;
        case (s_r.state)
            sum_pkg::ST_IDLE: begin
                if (start_req) begin
                    acc_clear   = 1'b1;
                    s_nxt.addr  = sum_pkg::CODE_FIRST_ADDR;
                    s_nxt.rd    = 1'b1;
                    s_nxt.state = sum_pkg::ST_FETCH;
                end
            end
            sum_pkg::ST_FETCH: begin
                if (start_req) begin
                    // a start between address and data must not be lost
                    acc_clear   = 1'b1;
                    s_nxt.addr  = sum_pkg::CODE_FIRST_ADDR;
                    s_nxt.rd    = 1'b1;
                    s_nxt.state = sum_pkg::ST_FETCH;
                end else begin
                    s_nxt.state = sum_pkg::ST_ADD;
                end
            end
            sum_pkg::ST_ADD: begin
                acc_add = 1'b1;
                if (start_req) begin
                    // a new start restarts the scan from the bottom
                    acc_clear   = 1'b1;
                    s_nxt.addr  = sum_pkg::CODE_FIRST_ADDR;
                    s_nxt.rd    = 1'b1;
                    s_nxt.state = sum_pkg::ST_FETCH;
                end else if (s_r.addr == sum_pkg::CODE_LAST_ADDR) begin
                    s_nxt.state = sum_pkg::ST_IDLE;
                end else begin
                    s_nxt.addr  = s_r.addr + 1'b1;
                    s_nxt.rd    = 1'b1;
                    s_nxt.state = sum_pkg::ST_FETCH;
                end
            end
            default: s_nxt.state = sum_pkg::ST_IDLE;
        endcase
        if (s_r.state == sum_pkg::ST_ADD && !start_req
            && s_r.addr == sum_pkg::CODE_LAST_ADDR) begin
            // final byte folded in here, since the accumulator lags a cycle
            {s_nxt.res_hi, s_nxt.res_lo} = acc_sum + {8'h00, code_data};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r        <= '0;
            s_r.state  <= sum_pkg::ST_IDLE;
            s_r.res_lo <= sum_pkg::RESULT_RESET;
            s_r.res_hi <= sum_pkg::RESULT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata    = s_r.rdata;
    assign pready    = s_r.ready;
    assign pslverr   = s_r.err;
    assign code_addr = s_r.addr;
    assign code_rd   = s_r.rd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_start_fetch;
        @(posedge pclk) disable iff (!presetn)
        start_req |=> code_rd && code_addr == sum_pkg::CODE_FIRST_ADDR;
    endproperty
    a_start_fetch: assert property (p_start_fetch)
        else $error("start did not begin scan at address zero");

    property p_zero_no_start;
        @(posedge pclk) disable iff (!presetn)
        (s_r.state == sum_pkg::ST_IDLE && !start_req) |=> !code_rd;
    endproperty
    a_zero_no_start: assert property (p_zero_no_start)
        else $error("scan began without a written one");

    property p_addr_range;
        @(posedge pclk) disable iff (!presetn)
        code_rd |-> code_addr <= sum_pkg::CODE_LAST_ADDR;
    endproperty
    a_addr_range: assert property (p_addr_range)
        else $error("fetch beyond last summed address");

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        (code_rd && !start_req && code_addr != sum_pkg::CODE_LAST_ADDR)
        ##2 !$past(start_req) |-> code_rd && code_addr == $past(code_addr, 2) + 1'b1;
    endproperty
    a_step: assert property (p_step)
        else $error("scan skipped or repeated an address");

    property p_result_load;
        @(posedge pclk) disable iff (!presetn)
        (s_r.state == sum_pkg::ST_ADD && !start_req && code_addr == sum_pkg::CODE_LAST_ADDR)
        |=> {s_r.res_hi, s_r.res_lo} == $past(acc_sum) + {8'h00, $past(code_data)};
    endproperty
    a_result_load: assert property (p_result_load)
        else $error("result not loaded with wrapped final sum");

    property p_low_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == sum_pkg::SUM_RESULT_LOW_ADDR)
        |=> pready && prdata == {24'h000000, $past(s_r.res_lo)};
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("low result read mismatch");

    property p_high_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == sum_pkg::SUM_RESULT_HIGH_ADDR)
        |=> pready && prdata == {24'h000000, $past(s_r.res_hi)};
    endproperty
    a_high_read: assert property (p_high_read)
        else $error("high result read mismatch");

    property p_acc_wrap;
        @(posedge pclk) disable iff (!presetn)
        (acc_add && !acc_clear) |=> acc_sum == 16'($past(acc_sum) + {8'h00, $past(code_data)});
    endproperty
    a_acc_wrap: assert property (p_acc_wrap)
        else $error("accumulator did not add byte modulo 65536");
endmodule
